// *** shared/sff_pkg.sv ***
// Shared constants, carriers and helpers of the synchronous FIFO block
package sff_pkg;

  // ************************************************************
  // Widths and sizes
  // ************************************************************
  localparam int SFF_DATA_W = 18;
  localparam int SFF_OFFS_W = 12;
  localparam int SFF_DEPTH_DEF = 256;
  localparam int SFF_DEPTH_SMALL = 256;
  localparam int SFF_DEPTH_MID = 512;
  localparam int SFF_DEPTH_MAX = 4096;
  localparam int SFF_STAGE_DEPTH = 4;

  // ************************************************************
  // Offset reset values, by array depth
  // ************************************************************
  localparam logic [SFF_OFFS_W-1:0] SFF_OFFS_SMALL = 12'h01f;
  localparam logic [SFF_OFFS_W-1:0] SFF_OFFS_MID = 12'h03f;
  localparam logic [SFF_OFFS_W-1:0] SFF_OFFS_LARGE = 12'h07f;

  // ************************************************************
  // Carriers
  // ************************************************************
  // Offset register selection, shared by the load write and load read sides
  typedef enum logic [1:0] {
    SFF_SEL_EMPTY = 2'b01,
    SFF_SEL_FULL = 2'b10
  } sff_sel_type;

  // All pin inputs, sampled together so they stay aligned through the synchroniser
  typedef struct packed {
    logic reset_n;
    logic write_clk;
    logic write_en_n;
    logic load_offset_n;
    logic read_clk;
    logic read_en_n;
    logic out_en_n;
    logic [SFF_DATA_W-1:0] data;
  } sff_pins_type;

  // Pin levels assumed before the first sample: device held in reset, strobes idle
  localparam sff_pins_type SFF_PINS_IDLE = '{
    reset_n: 1'b0,
    write_clk: 1'b0,
    write_en_n: 1'b1,
    load_offset_n: 1'b1,
    read_clk: 1'b0,
    read_en_n: 1'b1,
    out_en_n: 1'b1,
    data: 18'h00000
  };

  function automatic logic [SFF_OFFS_W-1:0] sff_default_offset(input int depth);
    if (depth <= SFF_DEPTH_SMALL) begin
      return SFF_OFFS_SMALL;
    end else if (depth <= SFF_DEPTH_MID) begin
      return SFF_OFFS_MID;
    end
    return SFF_OFFS_LARGE;
  endfunction : sff_default_offset

  function automatic sff_sel_type sff_next_sel(input sff_sel_type sel);
    sff_sel_type res;
    case (sel)
      SFF_SEL_EMPTY: res = SFF_SEL_FULL;
      SFF_SEL_FULL: res = SFF_SEL_EMPTY;
      default: res = SFF_SEL_EMPTY;
    endcase
    return res;
  endfunction : sff_next_sel

endpackage : sff_pkg

// *** hw/sff_stage_fifo.sv ***
// Small staging FIFO between the sampled write port and the storage array
module sff_stage_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  import sff_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
    $error("sff_stage_fifo: DEPTH must be a power of two >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_idx;
    logic [AW-1:0] rd_idx;
    logic [CW-1:0] cnt;
  } sff_stage_state_type;

  sff_stage_state_type st;
  sff_stage_state_type next_st;
  logic push;
  logic pop;

  assign in_ready = (st.cnt != CW'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data = st.mem[st.rd_idx];
  assign level = st.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr_idx] = in_data;
      next_st.wr_idx = AW'(st.wr_idx + 1'b1);
    end
    if (pop) begin
      next_st.rd_idx = AW'(st.rd_idx + 1'b1);
    end
    if (push && !pop) begin
      next_st.cnt = CW'(st.cnt + 1'b1);
    end else if (pop && !push) begin
      next_st.cnt = CW'(st.cnt - 1'b1);
    end
    if (!rst_n || flush) begin
      next_st.wr_idx = '0;
      next_st.rd_idx = '0;
      next_st.cnt = '0;
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

endmodule : sff_stage_fifo

// *** hw/sff_core.sv ***
// Synchronous FIFO with write port, reset and threshold offset loading
//
// Notes on behaviour
// - Reset returns write and read pointers to zero
// - Reset drives full, half, almost-full flags high
// - Reset drives empty and almost-empty flags low
// - Reset clears output data register to zero
// - Reset loads offsets with depth-dependent defaults
// - Write cycle starts on rising write clock
// - Load high, enable low: store word unless full
// - Words fill consecutive locations, independent of reads
// - Read data after read clock; drive only when enabled
// - Two twelve-bit offsets, writable and readable
// - First load write sets almost-empty offset
// - Second load write sets almost-full offset
// - Third load write wraps back to almost-empty
// - Partial offset loading then return to normal
// - Selection kept across exits from load mode
// - Load low, enable low: edges write offsets
// - Load reads return offsets in same order
// - Load low, enable high: write edge ignored
// - Separate read and write offset selectors
// - No normal read while buffer is empty
module sff_core #(
  parameter int DEPTH = sff_pkg::SFF_DEPTH_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reset_n,
  input wire logic write_clk,
  input wire logic write_en_n,
  input wire logic load_offset_n,
  input wire logic [sff_pkg::SFF_DATA_W-1:0] data_in,
  input wire logic read_clk,
  input wire logic read_en_n,
  input wire logic out_en_n,
  output logic [sff_pkg::SFF_DATA_W-1:0] data_out,
  output logic data_out_oe,
  output logic full_n,
  output logic empty_n,
  output logic half_full_n,
  output logic almost_full_n,
  output logic almost_empty_n
);
  import sff_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int SW = $clog2(SFF_STAGE_DEPTH + 1);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (DEPTH < 8 || DEPTH > SFF_DEPTH_MAX || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("sff_core: DEPTH must be a power of two from 8 to 4096");
  end
  // Full counts staged words, so the staging FIFO must stay shallower than the array
  if (SFF_STAGE_DEPTH >= DEPTH) begin : g_bad_stage
    $error("sff_core: staging FIFO must be shallower than the array");
  end

  typedef struct packed {
    sff_pins_type s1;
    sff_pins_type s2;
    sff_pins_type s3;
    sff_pins_type filt;
    logic [DEPTH-1:0][SFF_DATA_W-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
    logic [SFF_OFFS_W-1:0] empty_offset;
    logic [SFF_OFFS_W-1:0] full_offset;
    sff_sel_type wr_sel;
    sff_sel_type rd_sel;
    logic [SFF_DATA_W-1:0] data_out;
    logic data_out_oe;
    logic full_n;
    logic empty_n;
    logic half_full_n;
    logic almost_full_n;
    logic almost_empty_n;
  } sff_core_state_type;

  sff_core_state_type st;
  sff_core_state_type next_st;

  sff_pins_type pins;
  logic wr_edge;
  logic rd_edge;
  logic dev_reset;
  logic push_valid;
  logic push_ready;
  logic [SFF_DATA_W-1:0] drain_data;
  logic drain_valid;
  logic drain_ready;
  logic [SW-1:0] stage_level;
  logic read_pop;
  logic drain;
  int total;

  // ************************************************************
  // Helpers
  // ************************************************************
  // Device-level reset image; synchroniser stages are left running
  function automatic sff_core_state_type reset_device(input sff_core_state_type s);
    sff_core_state_type r;
    r = s;
    r.wptr = '0;
    r.rptr = '0;
    r.count = '0;
    r.full_n = 1'b1;
    r.half_full_n = 1'b1;
    r.almost_full_n = 1'b1;
    r.empty_n = 1'b0;
    r.almost_empty_n = 1'b0;
    r.data_out = '0;
    r.empty_offset = sff_default_offset(DEPTH);
    r.full_offset = sff_default_offset(DEPTH);
    r.wr_sel = SFF_SEL_EMPTY;
    r.rd_sel = SFF_SEL_EMPTY;
    return r;
  endfunction : reset_device

  // Low-active flag: asserted (0) when the value reaches the limit
  function automatic logic flag_at_least(input int value, input int limit);
    return (value >= limit) ? 1'b0 : 1'b1;
  endfunction : flag_at_least

  // Rising edge once both late stages read high while the settled level is still low
  function automatic logic rose_settled(input logic a, input logic b, input logic held);
    return a && b && !held;
  endfunction : rose_settled

  // A pin bit moves only when stages two and three agree, otherwise it holds
  function automatic sff_pins_type settle(input sff_pins_type a, input sff_pins_type b,
                                          input sff_pins_type held);
    return (a & ~(a ^ b)) | (held & (a ^ b));
  endfunction : settle

  // Offset read back on the low twelve bits; upper data bits read as zero
  function automatic logic [SFF_DATA_W-1:0] offset_word(input sff_core_state_type s);
    logic [SFF_DATA_W-1:0] w;
    w = '0;
    case (s.rd_sel)
      SFF_SEL_EMPTY: w[SFF_OFFS_W-1:0] = s.empty_offset;
      SFF_SEL_FULL: w[SFF_OFFS_W-1:0] = s.full_offset;
      default: w = s.data_out;
    endcase
    return w;
  endfunction : offset_word

  // Low-active flags for a level; empty and almost-empty see the array only
  function automatic sff_core_state_type set_flags(input sff_core_state_type s,
                                                   input int level);
    sff_core_state_type r;
    r = s;
    r.full_n = flag_at_least(level, DEPTH);
    r.half_full_n = flag_at_least(level, DEPTH / 2 + 1);
    r.almost_full_n = flag_at_least(level, DEPTH - int'(s.full_offset));
    r.empty_n = (s.count != '0);
    r.almost_empty_n = (int'(s.count) > int'(s.empty_offset));
    return r;
  endfunction : set_flags

  // ************************************************************
  // Pin sampling
  // ************************************************************
  // Data and strobes share one synchroniser, so a write sees the data of its own edge
  assign pins = '{
    reset_n: reset_n,
    write_clk: write_clk,
    write_en_n: write_en_n,
    load_offset_n: load_offset_n,
    read_clk: read_clk,
    read_en_n: read_en_n,
    out_en_n: out_en_n,
    data: data_in
  };

  // Filtered level moves only when stages two and three agree
  assign dev_reset = !st.filt.reset_n;
  assign wr_edge = rose_settled(st.s2.write_clk, st.s3.write_clk, st.filt.write_clk);
  assign rd_edge = rose_settled(st.s2.read_clk, st.s3.read_clk, st.filt.read_clk);

  // ************************************************************
  // Write staging
  // ************************************************************
  // Words counted as stored include those still staged, so full is honest
  assign total = int'(st.count) + int'(stage_level);

  // Enables and data come from the filtered copy, which settled before the edge
  assign push_valid = wr_edge && !dev_reset && st.filt.load_offset_n
                      && !st.filt.write_en_n && (total < DEPTH);

  // The array takes one access per cycle; a read pop stalls the drain
  assign read_pop = rd_edge && !dev_reset && st.filt.load_offset_n
                    && !st.filt.read_en_n && (st.count != '0);
  assign drain_ready = !read_pop && !dev_reset;
  assign drain = drain_valid && drain_ready;

  sff_stage_fifo #(
    .WIDTH(SFF_DATA_W),
    .DEPTH(SFF_STAGE_DEPTH)
  ) u_stage (
    .mclk(mclk),
    .rst_n(rst_n),
    .flush(dev_reset),
    .in_data(st.filt.data),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_data(drain_data),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .level(stage_level)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    int next_total;
    next_total = 0;
    next_st = st;
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.filt = settle(st.s2, st.s3, st.filt);
    next_st.data_out_oe = !st.filt.out_en_n;

    // Load-mode write: alternating offset targets, low twelve bits only
    if (wr_edge && !st.filt.load_offset_n && !st.filt.write_en_n) begin
      case (st.wr_sel)
        SFF_SEL_EMPTY: next_st.empty_offset = st.filt.data[SFF_OFFS_W-1:0];
        SFF_SEL_FULL: next_st.full_offset = st.filt.data[SFF_OFFS_W-1:0];
        default: next_st.empty_offset = st.empty_offset;
      endcase
      // Selection is never cleared when load goes high, only by reset
      next_st.wr_sel = sff_next_sel(st.wr_sel);
    end
    // Load low with write enable high falls through untouched

    // Drain the staging FIFO into consecutive array locations
    if (drain) begin
      next_st.mem[st.wptr] = drain_data;
      next_st.wptr = PW'(st.wptr + 1'b1);
    end

    // Read side: offsets in load mode, array words otherwise
    if (rd_edge && !st.filt.load_offset_n && !st.filt.read_en_n) begin
      next_st.data_out = offset_word(st);
      next_st.rd_sel = sff_next_sel(st.rd_sel);
    end else if (read_pop) begin
      next_st.data_out = st.mem[st.rptr];
      next_st.rptr = PW'(st.rptr + 1'b1);
    end

    if (drain && !read_pop) begin
      next_st.count = CW'(st.count + 1'b1);
    end else if (read_pop && !drain) begin
      next_st.count = CW'(st.count - 1'b1);
    end

    // Flags follow the updated occupancy; a push into staging counts in the same cycle
    next_total = int'(next_st.count) + int'(stage_level)
                 + ((push_valid && push_ready) ? 1 : 0) - (drain ? 1 : 0);
    next_st = set_flags(next_st, next_total);

    // Pin reset holds the device while the synchroniser keeps sampling
    if (dev_reset) begin
      next_st = reset_device(next_st);
    end

    // System reset: everything to constants, device held until the pin rises
    if (!rst_n) begin
      next_st = '0;
      next_st.s1 = SFF_PINS_IDLE;
      next_st.s2 = SFF_PINS_IDLE;
      next_st.s3 = SFF_PINS_IDLE;
      next_st.filt = SFF_PINS_IDLE;
      next_st = reset_device(next_st);
    end
  end

  // One register stage for all state; the system reset is folded into next_st
  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign data_out = st.data_out;
  assign data_out_oe = st.data_out_oe;
  assign full_n = st.full_n;
  assign empty_n = st.empty_n;
  assign half_full_n = st.half_full_n;
  assign almost_full_n = st.almost_full_n;
  assign almost_empty_n = st.almost_empty_n;

endmodule : sff_core

// *** bench/sff_core_props.sv ***
// Checker of the FIFO core pin behaviour
module sff_core_props #(
  parameter int DEPTH = sff_pkg::SFF_DEPTH_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reset_n,
  input wire logic write_clk,
  input wire logic write_en_n,
  input wire logic load_offset_n,
  input wire logic [sff_pkg::SFF_DATA_W-1:0] data_in,
  input wire logic read_clk,
  input wire logic read_en_n,
  input wire logic out_en_n,
  input wire logic [sff_pkg::SFF_DATA_W-1:0] data_out,
  input wire logic data_out_oe,
  input wire logic full_n,
  input wire logic empty_n,
  input wire logic half_full_n,
  input wire logic almost_full_n,
  input wire logic almost_empty_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import sff_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ********
  // Cycles since the last read clock (quiet) or read or write clock (still)
  // ********
  logic [3:0] quiet;
  logic [3:0] still;
  always_ff @(posedge mclk) begin
    if (!rst_n || !reset_n || read_clk) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n || !reset_n || read_clk || write_clk) begin
      still <= 4'h0;
    end else if (still != 4'hf) begin
      still <= still + 4'h1;
    end
  end
  // ********
  // Properties
  // ********
  a_reset_outs: assert property (
    $rose(rst_n) |-> full_n && half_full_n && almost_full_n && !empty_n
      && !almost_empty_n && data_out == '0 && !data_out_oe)
    else $error("outputs wrong after system reset");
  a_pin_reset: assert property (
    !reset_n [*7] |-> full_n && half_full_n && almost_full_n && !empty_n
      && !almost_empty_n && data_out == '0)
    else $error("outputs wrong while reset pin low");
  a_oe_follow: assert property (
    (reset_n && $stable(out_en_n)) [*8] |-> data_out_oe == !out_en_n)
    else $error("output enable not followed");
  a_out_quiet: assert property (quiet > 4'd6 |-> $stable(data_out))
    else $error("data out moved without a read");
  a_flags_still: assert property (
    still > 4'd8 |-> $stable({full_n, empty_n, half_full_n, almost_full_n, almost_empty_n}))
    else $error("flags moved without pin activity");
  a_full_flags: assert property (!full_n |-> !half_full_n && !almost_full_n)
    else $error("full without half and almost full");
  a_empty_ae: assert property (!empty_n |-> !almost_empty_n)
    else $error("empty without almost empty");
  a_half_data: assert property (!half_full_n |-> empty_n)
    else $error("half full while array empty");
  c_full: cover property (!full_n);
  c_half: cover property (!half_full_n);
  c_load_read: cover property (!load_offset_n && read_clk);
endmodule : sff_core_props

bind sff_core sff_core_props #(.DEPTH(DEPTH)) u_props (
  .mclk(mclk), .rst_n(rst_n), .reset_n(reset_n), .write_clk(write_clk),
  .write_en_n(write_en_n), .load_offset_n(load_offset_n), .data_in(data_in),
  .read_clk(read_clk), .read_en_n(read_en_n), .out_en_n(out_en_n),
  .data_out(data_out), .data_out_oe(data_out_oe), .full_n(full_n), .empty_n(empty_n),
  .half_full_n(half_full_n), .almost_full_n(almost_full_n),
  .almost_empty_n(almost_empty_n));

// *** bench/sff_pins_model.sv ***
// Producer and consumer driving the FIFO write and read pins
module sff_pins_model (
  input wire logic mclk,
  output logic write_clk,
  output logic write_en_n,
  output logic load_offset_n,
  output logic [sff_pkg::SFF_DATA_W-1:0] data_in,
  output logic read_clk,
  output logic read_en_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import sff_pkg::*;
  initial begin
    write_clk = 1'b0;
    read_clk = 1'b0;
    write_en_n = 1'b1;
    read_en_n = 1'b1;
    load_offset_n = 1'b1;
    data_in = 18'h15555;
  end
  // ********
  // One pin cycle, each phase five mclk so the filtered strobes stay aligned
  // ********
  // Only one side moves per call, so offsets are never read and written together
  task automatic pulse(input logic wr, input logic ld_n, input logic en_n,
    input logic [SFF_DATA_W-1:0] d);
    @(negedge mclk);
    load_offset_n = ld_n;
    if (wr) begin
      write_en_n = en_n;
      data_in = d;
    end else begin
      read_en_n = en_n;
    end
    repeat (5) @(negedge mclk);
    if (wr) begin
      write_clk = 1'b1;
    end else begin
      read_clk = 1'b1;
    end
    repeat (5) @(negedge mclk);
    write_clk = 1'b0;
    read_clk = 1'b0;
    repeat (5) @(negedge mclk);
    write_en_n = 1'b1;
    read_en_n = 1'b1;
    data_in = ~data_in;
  endtask : pulse
endmodule : sff_pins_model

// *** bench/sff_core_tb.sv ***
// Self-checking testbench of the synchronous FIFO core
module sff_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sff_pkg::*;
  localparam int DEPTH = 16;
  localparam logic [11:0] DEF_OFFS = SFF_OFFS_SMALL;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_n = 1'b0;
  logic out_en_n = 1'b0;
  logic write_clk, write_en_n, load_offset_n, read_clk, read_en_n;
  logic [SFF_DATA_W-1:0] data_in, data_out;
  logic data_out_oe, full_n, empty_n, half_full_n, almost_full_n, almost_empty_n;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  always #2.5 mclk = ~mclk;
  sff_core #(.DEPTH(DEPTH)) dut (.mclk(mclk), .rst_n(rst_n), .reset_n(reset_n),
    .write_clk(write_clk), .write_en_n(write_en_n), .load_offset_n(load_offset_n),
    .data_in(data_in), .read_clk(read_clk), .read_en_n(read_en_n), .out_en_n(out_en_n),
    .data_out(data_out), .data_out_oe(data_out_oe), .full_n(full_n), .empty_n(empty_n),
    .half_full_n(half_full_n), .almost_full_n(almost_full_n),
    .almost_empty_n(almost_empty_n));
  sff_pins_model pm (.mclk(mclk), .write_clk(write_clk), .write_en_n(write_en_n),
    .load_offset_n(load_offset_n), .data_in(data_in), .read_clk(read_clk),
    .read_en_n(read_en_n));
  // ********
  // Helpers
  // ********
  task automatic check(input logic [SFF_DATA_W-1:0] seen, input logic [SFF_DATA_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Offsets used once loaded: empty 2, full 3
  function automatic logic [4:0] flags_for(input int c);
    return {c < DEPTH, c <= DEPTH / 2, c < DEPTH - 3, c > 0, c > 2};
  endfunction : flags_for
  task automatic flags(input int c);
    check(18'({full_n, half_full_n, almost_full_n, empty_n, almost_empty_n}),
      18'(flags_for(c)));
  endtask : flags
  function automatic logic [17:0] word(input int i);
    return 18'h2a000 ^ 18'(i * 37);
  endfunction : word
  task automatic ld_rd(input logic [11:0] exp);
    pm.pulse(1'b0, 1'b0, 1'b0, 18'h0);
    check(data_out, {6'h0, exp});
  endtask : ld_rd
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      close_out();
    end
  end
  // ********
  // Scenarios
  // ********
  task automatic do_reset();
    @(negedge mclk);
    reset_n = 1'b0;
    repeat (7) @(negedge mclk);
    check(18'({full_n, half_full_n, almost_full_n}), 18'h00007);
    check(18'({empty_n, almost_empty_n}), 18'h00000);
    check(data_out, 18'h0);
    reset_n = 1'b1;
    repeat (6) @(negedge mclk);
  endtask : do_reset
  task automatic t_load();
    ld_rd(DEF_OFFS);
    ld_rd(DEF_OFFS);
    pm.pulse(1'b1, 1'b0, 1'b0, 18'h3f5a5);
    pm.pulse(1'b1, 1'b0, 1'b0, 18'h000c3);
    pm.pulse(1'b1, 1'b0, 1'b0, 18'h00002);
    pm.pulse(1'b1, 1'b0, 1'b1, 18'h00777);
    ld_rd(12'h002);
    ld_rd(12'h0c3);
    pm.pulse(1'b0, 1'b1, 1'b1, 18'h0);
    pm.pulse(1'b1, 1'b0, 1'b0, 18'h00003);
    ld_rd(12'h002);
    ld_rd(12'h003);
    flags(0);
  endtask : t_load
  task automatic t_fill();
    for (int i = 1; i <= DEPTH + 1; i++) begin
      pm.pulse(1'b1, 1'b1, 1'b0, word(i));
      flags(i > DEPTH ? DEPTH : i);
    end
    for (int i = 1; i <= DEPTH + 1; i++) begin
      pm.pulse(1'b0, 1'b1, 1'b0, 18'h0);
      check(data_out, word(i > DEPTH ? DEPTH : i));
      flags(i > DEPTH ? 0 : DEPTH - i);
    end
  endtask : t_fill
  task automatic t_oe();
    out_en_n = 1'b1;
    repeat (8) @(negedge mclk);
    check(18'(data_out_oe), 18'h0);
    out_en_n = 1'b0;
    repeat (8) @(negedge mclk);
    check(18'(data_out_oe), 18'h1);
  endtask : t_oe
  task automatic t_mid_reset();
    pm.pulse(1'b1, 1'b0, 1'b0, 18'h00abc);
    ld_rd(12'habc);
    for (int i = 1; i <= 3; i++) begin
      pm.pulse(1'b1, 1'b1, 1'b0, word(i));
    end
    do_reset();
    pm.pulse(1'b1, 1'b0, 1'b0, 18'h00002);
    ld_rd(12'h002);
    ld_rd(DEF_OFFS);
    pm.pulse(1'b1, 1'b1, 1'b0, word(99));
    pm.pulse(1'b0, 1'b1, 1'b0, 18'h0);
    check(data_out, word(99));
  endtask : t_mid_reset
  initial begin
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    do_reset();
    t_load();
    t_fill();
    t_oe();
    t_mid_reset();
    close_out();
  end
endmodule : sff_core_tb
